// ===== rtl/dds_core_pkg.sv
/*
  Constants for the synthesis core: register offsets, field positions,
  reset values and timing counts.
  Assumes a single 100 MHz core clock and an AHB-Lite register bus.
*/
// Notes on behaviour
// R1 - Control bit 16 selects sine or cosine
// R2 - Output frequency equals step word over 2^32
// R3 - Step words at or above 2^31 alias
// R4 - Phase offset added before amplitude lookup
// R5 - Amplitude scaled by factor over 4096 after lookup
// R6 - Modulation updates accepted at one sixteenth rate
// R7 - Software sets then clears the calibration bit
// R8 - Calibration runs 469632 clock periods
// R9 - Sync mode adds 16 sync clock periods
// R10 - Clock source bit selects PLL or direct
// R11 - 12-bit sample delivered every clock cycle
// R12 - 32-bit accumulator adds step word each cycle
package dds_core_pkg;
  localparam logic [7:0] OFS_CONFIG_ONE = 8'h00;
  localparam logic [7:0] OFS_CONFIG_TWO = 8'h04;
  localparam logic [7:0] OFS_CONFIG_THREE = 8'h08;
  localparam logic [7:0] OFS_CONFIG_FOUR = 8'h0c;
  localparam logic [7:0] OFS_FREQ = 8'h10;
  localparam logic [7:0] OFS_PHASE = 8'h14;
  localparam logic [7:0] OFS_AMPL = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam int SINE_SEL_BIT = 16;
  localparam int PLL_SEL_BIT = 0;
  localparam int MODUL_EN_BIT = 0;
  localparam int SYNC_EN_BIT = 1;
  localparam int DAC_CAL_BIT = 24;
  localparam int CAL_BUSY_BIT = 0;
  localparam int CAL_DONE_BIT = 1;
  localparam logic [31:0] RST_FREQ = 32'h0000_0000;
  localparam logic [15:0] RST_PHASE = 16'h0000;
  localparam logic [11:0] RST_AMPL = 12'hfff;
  localparam int CAL_PERIODS = 469632;
  localparam int SYNC_EXTRA_PERIODS = 16;
  localparam int MODUL_DIV = 16;
  localparam int LUT_BITS = 8;
endpackage

// ===== rtl/dds_core_tuning.sv
/*
  Direct digital synthesis core with AHB-Lite register slave.
  Assumes one clock CLK_I (core sample clock), a single bus master,
  and a sync input clock arriving asynchronously on a pin.
*/
module dds_core_tuning #(
  parameter int CAL_CYCLES = dds_core_pkg::CAL_PERIODS,
  parameter int SYNC_CYCLES = dds_core_pkg::SYNC_EXTRA_PERIODS
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic SYNC_IN_I,
  output logic [11:0] DAC_DATA_O,
  output logic PLL_SELECT_O,
  output logic CAL_BUSY_O
);
  localparam int LB = dds_core_pkg::LUT_BITS;

  logic [31:0] config_register_one_reg;
  logic [31:0] config_register_two_reg;
  logic [31:0] config_register_three_reg;
  logic [31:0] config_register_four_reg;
  logic [31:0] freq_step_word_reg;
  logic [15:0] phase_offset_word_reg;
  logic [11:0] amplitude_scale_factor_reg;
  logic [31:0] freq_active_reg;
  logic [15:0] phase_active_reg;
  logic [11:0] ampl_active_reg;
  logic [3:0] modul_div_reg;
  logic modul_tick;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic rd_pend_reg;
  logic [7:0] rd_addr_reg;
  logic [31:0] phase_acc_reg;
  logic [15:0] angle;
  logic [LB-1:0] lut_index;
  logic [11:0] mag;
  logic [11:0] mag_reg;
  logic neg_reg;
  logic [23:0] scaled;
  logic [11:0] signed_sample;
  logic sync_meta_reg;
  logic sync_sync_reg;
  logic sync_prev_reg;
  logic sync_rise;
  logic cal_bit_prev_reg;
  logic cal_done_reg;
  logic [31:0] cal_count_reg;
  logic [4:0] sync_count_reg;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_MAIN = 3'b010,
    CAL_SYNC = 3'b100
  } cal_state_e;
  cal_state_e cal_state_reg;

  // Quarter-wave sine magnitude, 11-bit full scale (2047)
  function automatic logic [11:0] quarter_sine(input logic [LB-1:0] idx);
    real x;
    x = $itor(idx) * 3.14159265358979 / (2.0 * (2.0 ** LB));
    return 12'($rtoi($sin(x) * 2047.0));
  endfunction

  logic [11:0] sine_lut [0:(1<<LB)-1];
  genvar g;
  generate
    for (g = 0; g < (1 << LB); g++)
    begin : g_lut
      assign sine_lut[g] = quarter_sine(LB'(g));
    end
  endgenerate

  // Bus write and read capture
  wire bus_go = HSEL_I && HREADY_I && HTRANS_I[1];
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= bus_go && HWRITE_I;
      rd_pend_reg <= bus_go && !HWRITE_I;
      if (bus_go)
      begin
        wr_addr_reg <= HADDR_I[7:0];
        rd_addr_reg <= HADDR_I[7:0];
      end
    end
  end

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      config_register_one_reg <= 32'h0000_0000;
      config_register_two_reg <= 32'h0000_0000;
      config_register_three_reg <= 32'h0000_0000;
      config_register_four_reg <= 32'h0000_0000;
      freq_step_word_reg <= dds_core_pkg::RST_FREQ;
      phase_offset_word_reg <= dds_core_pkg::RST_PHASE;
      amplitude_scale_factor_reg <= dds_core_pkg::RST_AMPL;
    end
    else if (wr_pend_reg)
    begin
      case (wr_addr_reg)
        dds_core_pkg::OFS_CONFIG_ONE: config_register_one_reg <= HWDATA_I;
        dds_core_pkg::OFS_CONFIG_TWO: config_register_two_reg <= HWDATA_I;
        dds_core_pkg::OFS_CONFIG_THREE: config_register_three_reg <= HWDATA_I;
        dds_core_pkg::OFS_CONFIG_FOUR: config_register_four_reg <= HWDATA_I;
        dds_core_pkg::OFS_FREQ: freq_step_word_reg <= HWDATA_I;
        dds_core_pkg::OFS_PHASE: phase_offset_word_reg <= HWDATA_I[15:0];
        dds_core_pkg::OFS_AMPL: amplitude_scale_factor_reg <= HWDATA_I[11:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      HRDATA_O <= 32'h0000_0000;
    else if (bus_go && !HWRITE_I)
    begin
      case (HADDR_I[7:0])
        dds_core_pkg::OFS_CONFIG_ONE: HRDATA_O <= config_register_one_reg;
        dds_core_pkg::OFS_CONFIG_TWO: HRDATA_O <= config_register_two_reg;
        dds_core_pkg::OFS_CONFIG_THREE: HRDATA_O <= config_register_three_reg;
        dds_core_pkg::OFS_CONFIG_FOUR: HRDATA_O <= config_register_four_reg;
        dds_core_pkg::OFS_FREQ: HRDATA_O <= freq_step_word_reg;
        dds_core_pkg::OFS_PHASE: HRDATA_O <= {16'h0000, phase_offset_word_reg};
        dds_core_pkg::OFS_AMPL: HRDATA_O <= {20'h00000, amplitude_scale_factor_reg};
        dds_core_pkg::OFS_STATUS: HRDATA_O <= {30'h0, cal_done_reg, cal_state_reg != CAL_IDLE};
        default: HRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  // Modulation update divider
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      modul_div_reg <= 4'h0;
    else
      modul_div_reg <= modul_div_reg + 4'h1;
  end
  assign modul_tick = (modul_div_reg == 4'(dds_core_pkg::MODUL_DIV - 1));

  // Control words take effect directly, or every 16th cycle when modulating
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      freq_active_reg <= dds_core_pkg::RST_FREQ;
      phase_active_reg <= dds_core_pkg::RST_PHASE;
      ampl_active_reg <= dds_core_pkg::RST_AMPL;
    end
    else if (!config_register_two_reg[dds_core_pkg::MODUL_EN_BIT] || modul_tick) // [R6]
    begin
      freq_active_reg <= freq_step_word_reg;
      phase_active_reg <= phase_offset_word_reg;
      ampl_active_reg <= amplitude_scale_factor_reg;
    end
  end

  // Accumulator wraps modulo 2^32, giving both direct and aliased tones
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      phase_acc_reg <= 32'h0000_0000;
    else
      phase_acc_reg <= phase_acc_reg + freq_active_reg; // [R12] [R2] [R3]
  end

  // Phase offset and cosine quarter shift ahead of the lookup
  always_comb
  begin
    angle = phase_acc_reg[31:16] + phase_active_reg; // [R4]
    if (!config_register_one_reg[dds_core_pkg::SINE_SEL_BIT])
      angle = angle + 16'h4000; // [R1]
    if (angle[14])
      lut_index = ~angle[13:14-LB];
    else
      lut_index = angle[13:14-LB];
    mag = sine_lut[lut_index];
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      mag_reg <= 12'h000;
      neg_reg <= 1'b0;
    end
    else
    begin
      mag_reg <= mag;
      neg_reg <= angle[15];
    end
  end

  // Scaling after lookup; offset binary sample for the converter
  always_comb
  begin
    scaled = mag_reg * ampl_active_reg; // [R5]
    signed_sample = neg_reg ? 12'h800 - {1'b0, scaled[22:12]} : 12'h800 + {1'b0, scaled[22:12]};
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      DAC_DATA_O <= 12'h800;
    else
      DAC_DATA_O <= signed_sample; // [R11]
  end

  assign PLL_SELECT_O = config_register_three_reg[dds_core_pkg::PLL_SEL_BIT]; // [R10]

  // Sync clock edge detect after two-stage synchroniser
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      sync_meta_reg <= 1'b0;
      sync_sync_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
    end
    else
    begin
      sync_meta_reg <= SYNC_IN_I;
      sync_sync_reg <= sync_meta_reg;
      sync_prev_reg <= sync_sync_reg;
    end
  end
  assign sync_rise = sync_sync_reg && !sync_prev_reg;

  // Calibration starts on the rising edge of the calibration bit
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      cal_bit_prev_reg <= 1'b0;
      cal_state_reg <= CAL_IDLE;
      cal_count_reg <= 32'h0;
      sync_count_reg <= 5'h0;
      cal_done_reg <= 1'b0;
    end
    else
    begin
      cal_bit_prev_reg <= config_register_four_reg[dds_core_pkg::DAC_CAL_BIT]; // [R7]
      case (cal_state_reg)
        CAL_IDLE:
        begin
          if (config_register_four_reg[dds_core_pkg::DAC_CAL_BIT] && !cal_bit_prev_reg)
          begin
            cal_state_reg <= CAL_MAIN;
            cal_count_reg <= 32'(CAL_CYCLES - 1);
            cal_done_reg <= 1'b0;
          end
        end
        CAL_MAIN:
        begin
          if (cal_count_reg == 32'h0) // [R8]
          begin
            if (config_register_two_reg[dds_core_pkg::SYNC_EN_BIT])
            begin
              cal_state_reg <= CAL_SYNC;
              sync_count_reg <= 5'(SYNC_CYCLES);
            end
            else
            begin
              cal_state_reg <= CAL_IDLE;
              cal_done_reg <= 1'b1;
            end
          end
          else
            cal_count_reg <= cal_count_reg - 32'h1;
        end
        CAL_SYNC:
        begin
          if (sync_count_reg == 5'h0) // [R9]
          begin
            cal_state_reg <= CAL_IDLE;
            cal_done_reg <= 1'b1;
          end
          else if (sync_rise)
            sync_count_reg <= sync_count_reg - 5'h1;
        end
        default: cal_state_reg <= CAL_IDLE;
      endcase
    end
  end

  assign CAL_BUSY_O = (cal_state_reg != CAL_IDLE);
endmodule // dds_core_tuning

// ===== sim/dds_core_checker.sv
/*
  Checker for the synthesis core: bus readback, clock select, calibration, samples.
  Assumes it is bound into the core and gets the calibration count.
*/
module dds_core_checker #(
  parameter int CAL_CYCLES = 20
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic [11:0] DAC_DATA_O,
  input wire logic PLL_SELECT_O,
  input wire logic CAL_BUSY_O
);
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  logic wp_reg, rp_reg, s_reg, c_reg;
  logic [7:0] a_reg, q_reg;
  logic [31:0] f_reg, b_reg;
  logic [11:0] m_reg;
  wire logic take = HSEL_I & HREADY_I & HTRANS_I[1];
  // Data phase tracking
  always_ff @(posedge CLK_I or posedge RST_I)
    if (RST_I)
    begin
      wp_reg <= 1'h0;
      rp_reg <= 1'h0;
    end
    else
    begin
      wp_reg <= take & HWRITE_I;
      rp_reg <= take & !HWRITE_I;
    end
  always_ff @(posedge CLK_I)
    a_reg <= HADDR_I[7:0];
  // Shadow copies of written registers
  always_ff @(posedge CLK_I or posedge RST_I)
    if (RST_I)
    begin
      f_reg <= 32'h0;
      m_reg <= 12'hfff;
      s_reg <= 1'h0;
      c_reg <= 1'h0;
    end
    else if (wp_reg)
      case (a_reg)
        8'h00: s_reg <= HWDATA_I[16];
        8'h0c: c_reg <= HWDATA_I[24];
        8'h10: f_reg <= HWDATA_I;
        8'h18: m_reg <= HWDATA_I[11:0];
        default: ;
      endcase
  // Quiet time since last write, busy length
  always_ff @(posedge CLK_I or posedge RST_I)
    if (RST_I)
    begin
      q_reg <= 8'h0;
      b_reg <= 32'h0;
    end
    else
    begin
      q_reg <= wp_reg ? 8'h0 : q_reg + {7'h0, q_reg != 8'hff};
      b_reg <= CAL_BUSY_O ? b_reg + 32'h1 : 32'h0;
    end
  a_pll_follow: assert property (wp_reg && a_reg == 8'h08 |=> PLL_SELECT_O == $past(HWDATA_I[0]))
    else $error("clock select does not follow register");
  a_cal_start: assert property ($rose(c_reg) && !CAL_BUSY_O |-> ##[0:3] CAL_BUSY_O)
    else $error("calibration did not start");
  a_busy_len: assert property ($fell(CAL_BUSY_O) |-> b_reg >= CAL_CYCLES)
    else $error("calibration too short");
  a_sine_read: assert property (rp_reg && a_reg == 8'h00 |-> HRDATA_O[16] == s_reg)
    else $error("wave select readback wrong");
  a_freq_read: assert property (rp_reg && a_reg == 8'h10 |-> HRDATA_O == f_reg)
    else $error("step word readback wrong");
  a_ampl_zero: assert property (q_reg > 8'h08 && m_reg == 12'h0 |-> DAC_DATA_O == 12'h800)
    else $error("zero scale not at midscale");
  a_dac_hold: assert property (q_reg > 8'h28 && f_reg == 32'h0 |-> $stable(DAC_DATA_O))
    else $error("sample moves with zero step");
  a_dac_moves: assert property (q_reg == 8'h28 && f_reg == 32'h1000_0000 && m_reg[11]
    |-> ##[1:16] !$stable(DAC_DATA_O))
    else $error("sample does not move");
  cover property ($fell(CAL_BUSY_O));
  cover property (rp_reg && a_reg == 8'h10);
  cover property (wp_reg && a_reg == 8'h08);
endmodule // dds_core_checker

bind dds_core_tuning dds_core_checker #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.*);

// ===== sim/dds_sync_src.sv
/*
  Model of the sync-input clock source beside the core.
  Assumes the bench enables it only around a synchronised calibration.
*/
module dds_sync_src #(
  parameter int HALF_NS = 37
) (
  input wire logic en_i,
  output logic sync_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Edges counted by the core, low while disabled
  initial
  begin
    sync_o = 1'h0;
    forever
    begin
      #(HALF_NS);
      sync_o = en_i ? !sync_o : 1'h0;
    end
  end
endmodule // dds_sync_src

// ===== sim/tb_dds_core_tuning.sv
/*
  Self-checking bench for the synthesis core.
  Assumes the checker is bound in and the sync source model is compiled.
*/
module tb_dds_core_tuning;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_I = 1'h0;
  logic RST_I = 1'h1;
  logic HSEL_I = 1'h0;
  logic HWRITE_I = 1'h0;
  logic rd_dp = 1'h0;
  logic sen = 1'h0;
  logic [1:0] HTRANS_I = 2'h0;
  logic [2:0] HSIZE_I = 3'h2;
  logic [31:0] HADDR_I = 32'h0;
  logic [31:0] HWDATA_I = 32'h0;
  logic [31:0] r, c0, v0, exp_q[$];
  logic [31:0] fq [2] = '{32'h1000_0000, 32'hf000_0000};
  wire logic [31:0] HRDATA_O;
  wire logic [11:0] DAC_DATA_O;
  wire logic HREADYOUT_O, HRESP_O, PLL_SELECT_O, CAL_BUSY_O, SYNC_IN_I;
  wire logic [31:0] dac = {20'h0, DAC_DATA_O};
  int fail_count = 0, n_checks = 0, bc = 0, n, seed = 32'hb39b126a;
  dds_core_tuning #(.CAL_CYCLES(20), .SYNC_CYCLES(2)) u_dut (.*, .HREADY_I(HREADYOUT_O));
  dds_sync_src u_sync (.en_i(sen), .sync_o(SYNC_IN_I));
  always #5 CLK_I = ~CLK_I;
  always @(posedge CLK_I)
    if (CAL_BUSY_O)
      bc++;
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task finish_test;
    $display("checks %0d failures %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task rdy;
    n = 0;
    do
    begin
      @(posedge CLK_I);
      n++;
    end
    while (HREADYOUT_O !== 1'h1 && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      finish_test;
    end
  endtask
  // One word transfer; for reads d is the expected data
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    HSEL_I <= 1'h1;
    HTRANS_I <= 2'h2;
    HWRITE_I <= w;
    HADDR_I <= {24'h0, a};
    rdy;
    HSEL_I <= 1'h0;
    HTRANS_I <= 2'h0;
    HWDATA_I <= d;
    rd_dp <= !w;
    if (!w)
      exp_q.push_back(d);
    rdy;
    rd_dp <= 1'h0;
  endtask
  task st;
    repeat (40) @(posedge CLK_I);
  endtask
  always @(posedge CLK_I)
    if (rd_dp)
      chk("read", exp_q.size() ? exp_q.pop_front() : 32'hdead_beef, HRDATA_O);
  initial
  begin
    repeat (100000) @(posedge CLK_I);
    fail_count++;
    finish_test;
  end
  initial
  begin
    repeat (20) @(posedge CLK_I);
    RST_I <= 1'h0;
    xfer(1'h0, 8'h10, 32'h0);
    xfer(1'h0, 8'h14, 32'h0);
    xfer(1'h0, 8'h18, 32'hfff);
    xfer(1'h0, 8'h24, 32'h0);
    repeat (4)
    begin
      r = $random(seed);
      xfer(1'h1, 8'h10, r);
      xfer(1'h0, 8'h10, r);
      xfer(1'h1, 8'h14, r);
      xfer(1'h0, 8'h14, {16'h0, r[15:0]});
      xfer(1'h1, 8'h18, r);
      xfer(1'h0, 8'h18, {20'h0, r[11:0]});
    end
    @(posedge CLK_I);
    RST_I <= 1'h1;
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'h0;
    xfer(1'h0, 8'h18, 32'hfff);
    xfer(1'h0, 8'h10, 32'h0);
    st;
    c0 = dac;
    chk("cos_peak", 32'h1, {31'h0, c0 > 32'h800});
    xfer(1'h1, 8'h00, 32'h1_0000);
    xfer(1'h0, 8'h00, 32'h1_0000);
    st;
    chk("sine_zero", 32'h800, dac);
    xfer(1'h1, 8'h14, 32'h4000);
    st;
    chk("sine_90", c0, dac);
    xfer(1'h1, 8'h18, 32'h800);
    st;
    v0 = 32'h800 + ((c0 - 32'h800) >> 1);
    chk("half", 32'h1, {31'h0, dac + 32'h1 >= v0 && dac <= v0 + 32'h1});
    xfer(1'h1, 8'h18, 32'h0);
    st;
    chk("zero_amp", 32'h800, dac);
    xfer(1'h1, 8'h18, 32'hfff);
    xfer(1'h1, 8'h14, 32'h0);
    foreach (fq[i])
    begin
      xfer(1'h1, 8'h10, fq[i]);
      st;
      v0 = dac;
      repeat (8) @(posedge CLK_I);
      r = dac;
      chk("mirror", 32'h1, {31'h0, v0 + r >= 32'hffe && v0 + r <= 32'h1002});
      repeat (8) @(posedge CLK_I);
      chk("period", v0, dac);
    end
    xfer(1'h1, 8'h10, 32'h0);
    for (int k = 1; k >= 0; k--)
    begin
      xfer(1'h1, 8'h08, k);
      xfer(1'h0, 8'h08, k);
      chk("pll", k, {31'h0, PLL_SELECT_O});
    end
    for (int k = 0; k < 2; k++)
    begin
      xfer(1'h1, 8'h04, {30'h0, k[0], 1'h0});
      sen <= k[0];
      bc = 0;
      xfer(1'h1, 8'h0c, 32'h0100_0000);
      xfer(1'h1, 8'h0c, 32'h0);
      n = 0;
      while (CAL_BUSY_O !== 1'h0 && n < 3000)
      begin
        @(posedge CLK_I);
        n++;
      end
      chk("cal_len", 32'h1, {31'h0, n < 3000 && (k ? bc > 22 : bc >= 20 && bc <= 22)});
      xfer(1'h0, 8'h1c, 32'h2);
    end
    finish_test;
  end
endmodule // tb_dds_core_tuning
